// file: core/mdes_pkg.sv
package mdes_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;  // Core clock period
  localparam int unsigned PCI_CLK_NS    = 30;  // One PCI clock
  localparam int unsigned PULSE_CYC     = (PCI_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  PULSE_CNT     = 2'(PULSE_CYC);

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_SMRAM = 8'h48;  // smram_map_control
  localparam logic [7:0] IDX_CTRL  = 8'h49;  // ecc_parity_control
  localparam logic [7:0] IDX_STAT  = 8'h4a;  // memory_error_status
  localparam logic [7:0] IDX_RSVD  = 8'h4b;  // reserved_byte_4b
  localparam logic [7:0] IDX_SRL   = 8'h4c;  // shadow_read_enable_low
  localparam logic [7:0] IDX_SRH   = 8'h4d;  // shadow_read_enable_high
  localparam logic [7:0] IDX_SWL   = 8'h4e;  // shadow_write_enable_low
  localparam logic [7:0] IDX_SWH   = 8'h4f;  // shadow_write_enable_high
  localparam logic [7:0] IDX_TEST  = 8'h60;  // forced check-bit value
  localparam logic [7:0] RST_BYTE  = 8'h00;  // Reset value of all bytes

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned SM_MAP_EN  = 0;  // Mapping enable
  localparam int unsigned SM_ANYTIME = 1;  // Access control
  localparam int unsigned SM_REG_LO  = 2;  // Region field low bit
  localparam int unsigned CT_MODE    = 0;  // 0 parity, 1 ECC
  localparam int unsigned CT_TEST    = 1;  // Test mode
  localparam int unsigned CT_SINGLE  = 4;  // Single-bit enable
  localparam int unsigned CT_MULTI   = 5;  // Multi/parity enable
  localparam int unsigned CT_LEVEL   = 6;  // Duration select
  localparam logic [7:0]  CT_WMASK   = 8'h73;  // Writable control bits
  localparam logic [7:0]  SM_WMASK   = 8'h0f;  // Implemented smram bits
  localparam int unsigned ST_SFLAG   = 0;  // Single-bit flag
  localparam int unsigned ST_SROW    = 1;  // Single row low bit
  localparam int unsigned ST_MFLAG   = 4;  // Multi/parity flag
  localparam int unsigned ST_MROW    = 5;  // Multi row low bit

  // ----------------------------------------
  // Address map constants
  // ----------------------------------------
  localparam logic [1:0] REG_D_TO_B  = 2'b00;
  localparam logic [1:0] REG_AB      = 2'b01;
  localparam logic [1:0] REG_3_TO_B  = 2'b10;
  localparam logic [3:0] SEG_3       = 4'h3;
  localparam logic [3:0] SEG_A       = 4'ha;
  localparam logic [3:0] SEG_B       = 4'hb;
  localparam logic [3:0] SEG_D       = 4'hd;
  localparam logic [1:0] SHADOW_TOP  = 2'b11;  // addr[19:18] of C0000h-FFFFFh

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       valid;   // One-cycle error event
    logic       multi;   // Parity or multi-bit ECC error
    logic       single;  // Single-bit ECC error
    logic [2:0] row;     // DRAM row of the failing access
  } mdes_err_s;

  typedef struct packed {
    logic        valid;  // One-cycle access request
    logic        write;  // 1 write, 0 read
    logic [31:0] addr;   // CPU logical address
  } mdes_acc_s;

endpackage : mdes_pkg

// file: core/mdes_sync.sv
`timescale 1ns/1ps
module mdes_sync
  import mdes_pkg::*;
(
  input  wire logic clk_i,   // Core clock
  input  wire logic rst_i,   // Sync reset, active high
  input  wire logic async_i, // Pin level
  input  wire logic init_i,  // Level assumed at reset
  output logic      sync_o   // Filtered level
);

  // ----------------------------------------
  // Three-stage capture
  // ----------------------------------------
  logic [2:0] stage_reg;  // Stage 0 feeds stage 1 only

  // Shift chain, no reset so meta stage sees only the pin
  always_ff @(posedge clk_i)
  begin
    stage_reg <= {stage_reg[1:0], async_i};
  end

  // Accept a change once stages 1 and 2 agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sync_o <= init_i;
    else if (stage_reg[1] == stage_reg[2])
      sync_o <= stage_reg[2];
  end

endmodule : mdes_sync

// file: core/mdes_smram.sv
`timescale 1ns/1ps
module mdes_smram
  import mdes_pkg::*;
(
  input  wire logic        map_en_i,  // Mapping enable
  input  wire logic        anytime_i, // Open outside SMM
  input  wire logic [1:0]  region_i,  // Window select
  input  wire logic        smm_n_i,   // Synced, low in SMM
  input  wire logic [19:0] addr_i,    // Address below 1 MB
  output logic             hit_o,     // Address in window
  output logic             local_o,   // Goes to DRAM
  output logic [19:0]      phys_o     // Remapped address
);

  logic open_w;  // SMRAM reachable now

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  always_comb
  begin
    open_w  = anytime_i | ~smm_n_i;
    hit_o   = 1'b0;
    local_o = 1'b1;
    phys_o  = addr_i;
    if (map_en_i)
    begin
      unique case (region_i)
        REG_D_TO_B:
        begin
          hit_o   = (addr_i[19:16] == SEG_D);
          local_o = open_w;
          phys_o  = {SEG_B, addr_i[15:0]};
        end
        REG_AB:
        begin
          hit_o   = (addr_i[19:16] == SEG_A) || (addr_i[19:16] == SEG_B);
          local_o = open_w;
        end
        REG_3_TO_B:
        begin
          hit_o = (addr_i[19:16] == SEG_3);
          // While SMRAM is closed (outside SMM, anytime bit clear) the segment stays ordinary DRAM
          if (open_w)
            phys_o = {SEG_B, addr_i[15:0]};
        end
        default:
        begin
          hit_o = 1'b0;  // Reserved code, no window
        end
      endcase
    end
  end

endmodule : mdes_smram

// file: core/mdes_core.sv
`timescale 1ns/1ps
module mdes_core
  import mdes_pkg::*;
#(
  parameter int unsigned ADDR_W = 32  // Host address width
)
(
  input  wire logic              clk_i,           // Core clock, 100 MHz
  input  wire logic              rst_i,           // Sync reset, active high
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,        // Cycle
  input  wire logic              wb_stb_i,        // Strobe
  input  wire logic              wb_we_i,         // Write
  input  wire logic [9:0]        wb_adr_i,        // Byte address
  input  wire logic [3:0]        wb_sel_i,        // Byte enables
  input  wire logic [31:0]       wb_dat_i,        // Write data
  output logic [31:0]            wb_dat_o,        // Read data
  output logic                   wb_ack_o,        // Acknowledge
  // Host side
  input  wire logic              smm_active_n_i,  // SMM pin, low active
  input  wire mdes_pkg::mdes_acc_s acc_i,         // Access to decode
  output logic                   acc_done_o,      // Decode result valid
  output logic                   acc_local_o,     // 1 DRAM, 0 PCI
  output logic [ADDR_W-1:0]      acc_phys_o,      // Physical address
  // DRAM integrity side
  input  wire mdes_pkg::mdes_err_s err_i,         // Error event
  output logic                   ecc_mode_o,      // 1 ECC, 0 parity
  output logic                   chk_multi_en_o,  // Multi/parity check on
  output logic                   chk_single_en_o, // Single-bit check on
  output logic                   test_mode_o,     // Force check bits
  output logic [7:0]             test_bits_o,     // Forced check bits
  // PCI side
  output logic                   system_error_n_o // System error, low active
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < 20 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 20 and 32");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] smram_reg;  // smram_map_control
  logic [7:0] ctrl_reg;   // ecc_parity_control
  logic [7:0] stat_reg;   // memory_error_status, built from the four below
  logic [2:0] mrow_reg;   // First multi/parity error row
  logic       mflag_reg;  // Multi/parity error flag
  logic [2:0] srow_reg;   // First single-bit error row
  logic       sflag_reg;  // Single-bit error flag
  logic [7:0] srl_reg;    // shadow_read_enable_low
  logic [7:0] srh_reg;    // shadow_read_enable_high
  logic [7:0] swl_reg;    // shadow_write_enable_low
  logic [7:0] swh_reg;    // shadow_write_enable_high
  logic [7:0] test_reg;   // Forced check-bit value
  logic [1:0] pulse_reg;  // Pulse cycles left
  logic       smm_n_w;    // Synced SMM level

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       req_w;    // New request this cycle
  logic       wr_w;     // Write, low lane enabled
  logic [7:0] idx_w;    // Word index
  logic [7:0] wbyte_w;  // Low write byte

  assign req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx_w   = wb_adr_i[9:2];
  assign wr_w    = req_w & wb_we_i & wb_sel_i[0];
  assign wbyte_w = wb_dat_i[7:0];

  // Register write strobe for one index
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_w && (idx_w == idx);
  endfunction : wr_hit

  // Shadow enable lookup for an address in C0000h-FFFFFh
  function automatic logic shadow_en(input logic [7:0] lo,
                                     input logic [7:0] hi,
                                     input logic [19:0] a);
    shadow_en = a[17] ? hi[a[16:14]] : lo[a[16:14]];
  endfunction : shadow_en

  // ----------------------------------------
  // Acknowledge: one cycle after the strobe
  // ----------------------------------------
  // Ack drops the cycle after it is given, so a strobe still held
  // in the ack cycle is not taken twice.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req_w;
  end

  // Read data, unmapped indices read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req_w)
    begin
      unique case (idx_w)
        IDX_SMRAM: wb_dat_o <= {24'h00_0000, smram_reg};
        IDX_CTRL:  wb_dat_o <= {24'h00_0000, ctrl_reg};
        IDX_STAT:  wb_dat_o <= {24'h00_0000, stat_reg};
        IDX_SRL:   wb_dat_o <= {24'h00_0000, srl_reg};
        IDX_SRH:   wb_dat_o <= {24'h00_0000, srh_reg};
        IDX_SWL:   wb_dat_o <= {24'h00_0000, swl_reg};
        IDX_SWH:   wb_dat_o <= {24'h00_0000, swh_reg};
        IDX_TEST:  wb_dat_o <= {24'h00_0000, test_reg};
        default:   wb_dat_o <= 32'h0000_0000;  // Incl. reserved 4Bh
      endcase
    end
  end

  // ----------------------------------------
  // Plain read/write registers
  // ----------------------------------------
  // SMRAM mapping, only bits 3-0 kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      smram_reg <= RST_BYTE;
    else if (wr_hit(IDX_SMRAM))
      smram_reg <= wbyte_w & SM_WMASK;
  end

  // Integrity control, reserved bits stay zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= RST_BYTE;
    else if (wr_hit(IDX_CTRL))
      ctrl_reg <= wbyte_w & CT_WMASK;
  end

  // Shadow enables, one bit per 16 KB segment
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srl_reg <= RST_BYTE;
      srh_reg <= RST_BYTE;
      swl_reg <= RST_BYTE;
      swh_reg <= RST_BYTE;
    end
    else
    begin
      if (wr_hit(IDX_SRL))
        srl_reg <= wbyte_w;
      if (wr_hit(IDX_SRH))
        srh_reg <= wbyte_w;
      if (wr_hit(IDX_SWL))
        swl_reg <= wbyte_w;
      if (wr_hit(IDX_SWH))
        swh_reg <= wbyte_w;
    end
  end

  // Forced check-bit value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_reg <= RST_BYTE;
    else if (wr_hit(IDX_TEST))
      test_reg <= wbyte_w;
  end

  // ----------------------------------------
  // Integrity controls to the DRAM datapath
  // ----------------------------------------
  logic multi_en_w;   // Multi/parity check active
  logic single_en_w;  // Single-bit check active

  assign multi_en_w  = ctrl_reg[CT_MULTI];
  assign single_en_w = ctrl_reg[CT_SINGLE] & ctrl_reg[CT_MODE];

  // Straight from the control flops
  assign ecc_mode_o      = ctrl_reg[CT_MODE];
  assign chk_multi_en_o  = ctrl_reg[CT_MULTI];
  assign chk_single_en_o = ctrl_reg[CT_SINGLE];
  assign test_mode_o     = ctrl_reg[CT_TEST];
  assign test_bits_o     = test_reg;

  // ----------------------------------------
  // Error logging
  // ----------------------------------------
  logic set_m_w;  // Accepted multi/parity error
  logic set_s_w;  // Accepted single-bit error
  logic clr_m_w;  // Software clear of multi flag
  logic clr_s_w;  // Software clear of single flag

  // Disabled checks discard their events entirely
  assign set_m_w = err_i.valid & err_i.multi & multi_en_w;
  assign set_s_w = err_i.valid & err_i.single & single_en_w;
  assign clr_m_w = wr_hit(IDX_STAT) & wbyte_w[ST_MFLAG];
  assign clr_s_w = wr_hit(IDX_STAT) & wbyte_w[ST_SFLAG];

  // Status byte as software sees it; every field has a single driver
  assign stat_reg = {mrow_reg, mflag_reg, srow_reg, sflag_reg};

  // Multi/parity flag and row; set beats a same-cycle clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mrow_reg  <= 3'h0;
      mflag_reg <= 1'b0;
    end
    else if (set_m_w)
    begin
      // Row kept from the first error while the flag stands, so a
      // burst still points software at the row that failed first
      if (!mflag_reg || clr_m_w)
        mrow_reg <= err_i.row;
      mflag_reg <= 1'b1;
    end
    else if (clr_m_w)
      mflag_reg <= 1'b0;
  end

  // Single-bit flag and row, same policy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srow_reg  <= 3'h0;
      sflag_reg <= 1'b0;
    end
    else if (set_s_w)
    begin
      if (!sflag_reg || clr_s_w)
        srow_reg <= err_i.row;
      sflag_reg <= 1'b1;
    end
    else if (clr_s_w)
      sflag_reg <= 1'b0;
  end

  // ----------------------------------------
  // System error output
  // ----------------------------------------
  logic err_evt_w;  // Any reported error
  logic flags_w;    // Any flag still set

  assign err_evt_w = set_m_w | set_s_w;
  assign flags_w   = stat_reg[ST_MFLAG] | stat_reg[ST_SFLAG];

  // Pulse timer, one PCI clock long
  // Rounded up to whole core cycles, so the pulse never falls short
  // of a PCI clock; a new event restarts it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pulse_reg <= 2'b00;
    else if (err_evt_w && !ctrl_reg[CT_LEVEL])
      pulse_reg <= PULSE_CNT;
    else if (pulse_reg != 2'b00)
      pulse_reg <= pulse_reg - 2'b01;
  end

  // Level mode holds while any flag stands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      system_error_n_o <= 1'b1;
    else if (ctrl_reg[CT_LEVEL])
      system_error_n_o <= ~(flags_w | err_evt_w);
    else
      system_error_n_o <= ~((err_evt_w) || (pulse_reg > 2'b01));
  end

  // ----------------------------------------
  // SMM input
  // ----------------------------------------
  mdes_sync u_smm_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (smm_active_n_i),
    .init_i  (1'b1),
    .sync_o  (smm_n_w)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic        low_mb_w;  // Access below 1 MB
  logic        sm_hit_w;  // In SMRAM window
  logic        sm_loc_w;  // Window grants DRAM
  logic [19:0] sm_phys_w; // Window physical address
  logic        shadow_w;  // In C0000h-FFFFFh
  logic        sh_en_w;   // Enable for this direction

  assign low_mb_w = (acc_i.addr[ADDR_W-1:20] == '0);
  assign shadow_w = low_mb_w && (acc_i.addr[19:18] == SHADOW_TOP);

  // Read and write tables looked up separately
  assign sh_en_w = acc_i.write ? shadow_en(swl_reg, swh_reg, acc_i.addr[19:0])
                               : shadow_en(srl_reg, srh_reg, acc_i.addr[19:0]);

  mdes_smram u_smram (
    .map_en_i  (smram_reg[SM_MAP_EN]),
    .anytime_i (smram_reg[SM_ANYTIME]),
    .region_i  (smram_reg[SM_REG_LO +: 2]),
    .smm_n_i   (smm_n_w),
    .addr_i    (acc_i.addr[19:0]),
    .hit_o     (sm_hit_w),
    .local_o   (sm_loc_w),
    .phys_o    (sm_phys_w)
  );

  // Registered decode; the SMRAM window takes priority
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_done_o  <= 1'b0;
      acc_local_o <= 1'b0;
      acc_phys_o  <= '0;
    end
    else
    begin
      acc_done_o <= acc_i.valid;
      if (acc_i.valid)
      begin
        acc_phys_o <= acc_i.addr[ADDR_W-1:0];
        if (low_mb_w && sm_hit_w)
        begin
          acc_local_o      <= sm_loc_w;
          acc_phys_o[19:0] <= sm_phys_w;
        end
        else if (shadow_w)
          acc_local_o <= sh_en_w;
        else
          acc_local_o <= 1'b1;     // Other areas left to DRAM
      end
    end
  end

endmodule : mdes_core

// file: bench/mdes_core_props.sv
`timescale 1ns/1ps
module mdes_core_props
  import mdes_pkg::*;
#(
  parameter int unsigned ADDR_W = 32  // Host address width
)
(
  input  wire logic                clk_i,            // Core clock
  input  wire logic                rst_i,            // Sync reset
  input  wire logic                wb_cyc_i,         // Bus cycle
  input  wire logic                wb_stb_i,         // Bus strobe
  input  wire logic                wb_ack_o,         // Bus acknowledge
  input  wire mdes_pkg::mdes_acc_s acc_i,            // Decode request
  input  wire logic                acc_done_o,       // Decode result valid
  input  wire logic                acc_local_o,      // DRAM or PCI
  input  wire logic [ADDR_W-1:0]   acc_phys_o,       // Physical address
  input  wire mdes_pkg::mdes_err_s err_i,            // Error event
  input  wire logic                ecc_mode_o,       // ECC selected
  input  wire logic                chk_multi_en_o,   // Multi check on
  input  wire logic                chk_single_en_o,  // Single check on
  input  wire logic                system_error_n_o  // Error line, low active
);
  // ----------------------------------------
  // Single domain, so one clock and one reset for all
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  done_next_a: assert property (acc_i.valid |=> acc_done_o)
    else $error("decode result missing after request");
  done_idle_a: assert property (!acc_i.valid |=> !acc_done_o)
    else $error("decode result without request");
  // Above 1 MB nothing is remapped and all goes to DRAM
  high_mem_a: assert property (acc_i.valid && (acc_i.addr[31:20] != 12'h000)
    |=> acc_local_o && (acc_phys_o == $past(acc_i.addr[ADDR_W-1:0])))
    else $error("high memory decode wrong");
  multi_serr_a: assert property (err_i.valid && err_i.multi && chk_multi_en_o
    |=> !system_error_n_o)
    else $error("multi-bit error not reported");
  multi_off_a: assert property (err_i.valid && err_i.multi && !err_i.single
    && !chk_multi_en_o && system_error_n_o |=> system_error_n_o)
    else $error("disabled multi-bit error reported");
  single_serr_a: assert property (err_i.valid && err_i.single
    && chk_single_en_o && ecc_mode_o |=> !system_error_n_o)
    else $error("single-bit error not reported");
  single_off_a: assert property (err_i.valid && err_i.single && !err_i.multi
    && !(chk_single_en_o && ecc_mode_o) && system_error_n_o |=> system_error_n_o)
    else $error("disabled single-bit error reported");
endmodule : mdes_core_props

bind mdes_core mdes_core_props #(.ADDR_W(ADDR_W)) i_mdes_core_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .acc_i(acc_i), .acc_done_o(acc_done_o),
  .acc_local_o(acc_local_o), .acc_phys_o(acc_phys_o), .err_i(err_i),
  .ecc_mode_o(ecc_mode_o), .chk_multi_en_o(chk_multi_en_o),
  .chk_single_en_o(chk_single_en_o), .system_error_n_o(system_error_n_o));

// file: bench/mdes_far_model.sv
`timescale 1ns/1ps
module mdes_far_model
  import mdes_pkg::*;
(
  input  wire logic       clk_i,   // Core clock
  output mdes_pkg::mdes_acc_s acc_o,   // Host access request
  output mdes_pkg::mdes_err_s err_o,   // DRAM error event
  output logic            smm_n_o  // SMM pin, low active
);
  // ----------------------------------------
  // Idle values at time zero
  // ----------------------------------------
  initial
  begin
    acc_o   = '0;
    err_o   = '0;
    smm_n_o = 1'b1;
  end

  // One-cycle access; address turned over afterwards so stale values do not match
  task automatic access(input logic [31:0] a, input logic w);
    @(posedge clk_i);
    acc_o <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clk_i);
    acc_o <= '{valid: 1'b0, write: ~w, addr: ~a};
  endtask : access

  // One-cycle error event
  task automatic fault(input logic m, input logic s, input logic [2:0] row);
    @(posedge clk_i);
    err_o <= '{valid: 1'b1, multi: m, single: s, row: row};
    @(posedge clk_i);
    err_o <= '{valid: 1'b0, multi: ~m, single: ~s, row: ~row};
  endtask : fault

  // Pin change, then time for the synchroniser to settle
  task automatic set_smm(input logic v);
    @(posedge clk_i);
    smm_n_o <= v;
    repeat (6) @(posedge clk_i);
  endtask : set_smm
endmodule : mdes_far_model

// file: bench/tb_mdes_core.sv
`timescale 1ns/1ps
module tb_mdes_core;
  import mdes_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, acc_phys;
  logic        wb_ack_o, smm_n, acc_done, acc_local, ecc_mode, mul_en, sgl_en, tmode, serr_n;
  logic [7:0]  tbits, rd;
  mdes_acc_s   acc;
  mdes_err_s   err;
  int          error_cnt = 0, check_count = 0;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  mdes_far_model i_mdes_far_model (.clk_i(clk_i), .acc_o(acc), .err_o(err), .smm_n_o(smm_n));
  mdes_core #(.ADDR_W(32)) i_mdes_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smm_active_n_i(smm_n), .acc_i(acc),
    .acc_done_o(acc_done), .acc_local_o(acc_local), .acc_phys_o(acc_phys), .err_i(err),
    .ecc_mode_o(ecc_mode), .chk_multi_en_o(mul_en), .chk_single_en_o(sgl_en),
    .test_mode_o(tmode), .test_bits_o(tbits), .system_error_n_o(serr_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic single cycle; data taken at the ack edge, then released
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      test_done();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, writable bits, reserved and unmapped places
  task automatic t_regs();
    logic [7:0] idx [10] = '{IDX_SMRAM, IDX_CTRL, IDX_STAT, IDX_RSVD, IDX_SRL,
                             IDX_SRH, IDX_SWL, IDX_SWH, IDX_TEST, 8'h70};
    logic [7:0] ex [10] = '{8'h0f, 8'h73, 8'h00, 8'h00, 8'hff,
                            8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 10; i++)
    begin
      wb(1'b0, idx[i], 8'h00, rd);
      chk("reset value", rd, 32'(RST_BYTE));
      wb(1'b1, idx[i], 8'hff, rd);
      wb(1'b0, idx[i], 8'h00, rd);
      chk("read back", rd, 32'(ex[i]));
    end
    chk("control outputs", {ecc_mode, tmode, sgl_en, mul_en}, 32'hf);
    chk("forced bits", tbits, 32'hff);
    wb(1'b1, IDX_CTRL, 8'h00, rd);
    wb(1'b1, IDX_SMRAM, 8'h00, rd);
    chk("control cleared", {ecc_mode, tmode, sgl_en, mul_en}, 32'h0);
  endtask : t_regs

  // Every 16 KB segment in both directions, read and write tables disagreeing
  task automatic t_shadow();
    logic [7:0] pat [4] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3};
    for (int t = 0; t < 4; t++)
      wb(1'b1, 8'(IDX_SRL + t), pat[t], rd);
    for (int s = 0; s < 16; s++)
      for (int w = 0; w < 2; w++)
      begin
        i_mdes_far_model.access(32'hc0120 + 32'(s) * 32'h4000, w[0]);
        #1;
        chk("shadow route", acc_local, 32'(pat[2 * w + s / 8][s % 8]));
      end
    i_mdes_far_model.access(32'h0100_0000, 1'b0);
    #1;
    chk("high memory", acc_local, 32'h1);
  endtask : t_shadow

  // Rows: map control, smm pin, address, local, physical address
  task automatic t_smram();
    logic [55:0] tab [11] = '{56'h01_0_d0123_1_b0123, 56'h01_1_d0123_0_00000,
      56'h03_1_d0123_1_b0123, 56'h05_1_a0040_0_00000, 56'h05_0_a0040_1_a0040,
      56'h07_1_b1000_1_b1000, 56'h09_0_30010_1_b0010, 56'h09_1_30010_1_30010,
      56'h0b_1_30010_1_b0010, 56'h00_0_d0123_0_00000, 56'h0d_0_d0123_0_00000};
    // Last two fall into the read table, whose D0000h bit is clear
    foreach (tab[i])
    begin
      wb(1'b1, IDX_SMRAM, tab[i][55:48], rd);
      i_mdes_far_model.set_smm(tab[i][44]);
      i_mdes_far_model.access({12'h0, tab[i][43:24]}, 1'b0);
      #1;
      chk("smram route", acc_local, 32'(tab[i][20]));
      if (tab[i][20])
        chk("smram address", acc_phys, {12'h0, tab[i][19:0]});
    end
  endtask : t_smram

  // Logging, clearing, pulse and level reporting, disabled checks
  task automatic t_err();
    int n;
    wb(1'b1, IDX_CTRL, 8'h20, rd);
    i_mdes_far_model.fault(1'b1, 1'b0, 3'd5);
    n = 0;
    repeat (10)
    begin
      #1;
      if (serr_n === 1'b0)
        n++;
      @(posedge clk_i);
    end
    chk("pulse length", n, 32'(PULSE_CNT));
    i_mdes_far_model.fault(1'b1, 1'b0, 3'd2);
    wb(1'b1, IDX_STAT, 8'h00, rd);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("parity log", rd, 32'hb0);
    wb(1'b1, IDX_STAT, 8'h10, rd);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("flag cleared", rd & 8'h11, 32'h0);
    wb(1'b1, IDX_CTRL, 8'h30, rd);
    i_mdes_far_model.fault(1'b0, 1'b1, 3'd3);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("single in parity", rd & 8'h11, 32'h0);
    wb(1'b1, IDX_CTRL, 8'h71, rd);
    i_mdes_far_model.fault(1'b0, 1'b1, 3'd6);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("single log", rd & 8'h0f, 32'hd);
    i_mdes_far_model.fault(1'b1, 1'b0, 3'd1);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("multi log", rd & 8'hf0, 32'h30);
    wb(1'b1, IDX_STAT, 8'h01, rd);
    repeat (5) @(posedge clk_i);
    #1;
    chk("level held", serr_n, 32'h0);
    wb(1'b1, IDX_STAT, 8'h10, rd);
    repeat (2) @(posedge clk_i);
    #1;
    chk("level released", serr_n, 32'h1);
    wb(1'b1, IDX_CTRL, 8'h01, rd);
    i_mdes_far_model.fault(1'b1, 1'b0, 3'd4);
    i_mdes_far_model.fault(1'b0, 1'b1, 3'd4);
    #1;
    chk("disabled report", serr_n, 32'h1);
    wb(1'b0, IDX_STAT, 8'h00, rd);
    chk("disabled check", rd & 8'h11, 32'h0);
  endtask : t_err

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_shadow();
    t_smram();
    t_err();
    test_done();
  end
endmodule : tb_mdes_core
